// ---- common/aui_pkg.sv ----
// shared constants and types for the lane sleep and equalization feedback block
package aui_pkg;

	// ****************************************
	// link geometry
	// ****************************************
	localparam int AUI_NUM_LANES = 8;
	localparam int AUI_NUM_DIRS = 2;
	localparam int AUI_DIR_EGRESS = 0;
	localparam int AUI_DIR_INGRESS = 1;
	localparam int AUI_WORD_W = 16;
	localparam logic [AUI_WORD_W-1:0] AUI_ALERT_WORD = 16'hFF00;

	// ****************************************
	// equalization step ranges
	// ****************************************
	localparam logic [1:0] AUI_PRE_MAX = 2'h3;
	localparam logic [2:0] AUI_POST_MAX = 3'h5;

	// ****************************************
	// timing
	// ****************************************
	localparam int AUI_CLK_PERIOD_NS = 10;
	localparam int AUI_SD_OK_MAX_NS = 500;
	localparam int AUI_SD_OK_MAX_CYC = AUI_SD_OK_MAX_NS / AUI_CLK_PERIOD_NS;

	// ****************************************
	// register map (byte addresses)
	// ****************************************
	localparam int AUI_ADDR_W = 8;
	localparam logic [AUI_ADDR_W-1:0] AUI_REG_CTRL = 8'h00;
	localparam logic [AUI_ADDR_W-1:0] AUI_REG_STATUS = 8'h04;
	localparam logic [AUI_ADDR_W-1:0] AUI_REG_EQ_BASE = 8'h40;
	localparam int AUI_CTRL_TXDIS_BIT = 0;
	localparam int AUI_CTRL_EQFB_BIT = 1;
	localparam logic [1:0] AUI_CTRL_RESET = 2'h0;
	// eq entry fields: request word low, remote steps, local steps
	localparam int AUI_EQ_REQ_LSB = 0;
	localparam int AUI_EQ_REM_LSB = 8;
	localparam int AUI_EQ_LOC_LSB = 16;

	// ****************************************
	// types
	// ****************************************
	typedef enum logic [1:0] {
		AUI_MODE_DATA = 2'b00,
		AUI_MODE_ALERT = 2'b01,
		AUI_MODE_QUIET = 2'b10
	} aui_mode_t;

	typedef struct packed {
		logic flag;
		logic [1:0] pre;
		logic [2:0] post;
	} aui_step_t;

	localparam aui_step_t AUI_STEP_RESET = 6'h00;

	typedef enum logic [0:0] {
		AUI_BUS_IDLE = 1'b0,
		AUI_BUS_ACK = 1'b1
	} aui_bus_state_t;

endpackage

// ---- verilog/aui_tx_sleep.sv ----
// one direction of transmit lane shutdown and alert pattern insertion
`timescale 1ns/1ns
module aui_tx_sleep #(
	parameter int NUM_LANES = aui_pkg::AUI_NUM_LANES
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// control
	input wire logic disable_en,
	input wire logic sleep_gate,
	input wire aui_pkg::aui_mode_t tx_mode,
	// lane data
	input wire logic [NUM_LANES-1:0][aui_pkg::AUI_WORD_W-1:0] lane_data_in,
	output logic [NUM_LANES-1:0][aui_pkg::AUI_WORD_W-1:0] lane_data_out,
	output logic [NUM_LANES-1:0] lane_tx_off
);
	import aui_pkg::*;

	logic off_d;
	logic off_q;
	logic [NUM_LANES-1:0][AUI_WORD_W-1:0] data_d;
	logic [NUM_LANES-1:0][AUI_WORD_W-1:0] data_q;

	// ****************************************
	// shutdown decision
	// ****************************************
	always_comb begin
		// any mode other than quiet turns every lane back on
		off_d = disable_en && sleep_gate && (tx_mode == AUI_MODE_QUIET);
	end

	// ****************************************
	// per lane data path
	// ****************************************
	genvar g;
	generate
		for (g = 0; g < NUM_LANES; g++) begin : g_lane
			always_comb begin
				if (tx_mode == AUI_MODE_ALERT) begin
					data_d[g] = AUI_ALERT_WORD;
				end else begin
					data_d[g] = lane_data_in[g];
				end
			end
		end
	endgenerate

	always_ff @(posedge mclk) begin
		if (rst) begin
			off_q <= 1'b0;
			data_q <= '0;
		end else begin
			off_q <= off_d;
			data_q <= data_d;
		end
	end

	assign lane_tx_off = {NUM_LANES{off_q}};
	assign lane_data_out = data_q;

endmodule

// ---- verilog/aui_energy_detect.sv ----
// one direction of global energy detect
`timescale 1ns/1ns
module aui_energy_detect (
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// link receive side
	input wire aui_pkg::aui_mode_t rx_mode,
	input wire logic energy_in,
	input wire logic alert_valid,
	// indication
	output logic signal_ok
);
	import aui_pkg::*;

	aui_mode_t prev_d;
	aui_mode_t prev_q;
	logic ok_d;
	logic ok_q;

	// ****************************************
	// detect state
	// ****************************************
	always_comb begin
		prev_d = rx_mode;
		ok_d = ok_q;
		if (rx_mode == AUI_MODE_QUIET) begin
			if (alert_valid) begin
				// answered next edge, well inside the deadline
				ok_d = 1'b1;
			end else if (prev_q == AUI_MODE_DATA && !energy_in) begin
				ok_d = 1'b0;
			end
			// otherwise hold: no rise without a valid alert
		end else begin
			ok_d = energy_in;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			prev_q <= AUI_MODE_DATA;
			ok_q <= 1'b0;
		end else begin
			prev_q <= prev_d;
			ok_q <= ok_d;
		end
	end

	assign signal_ok = ok_q;

endmodule

// ---- verilog/aui_lane_sleep_and_eq_feedback.sv ----
// top of lane sleep, energy detect and equalization feedback with register slave
//
// Decided for this implementation: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ns

module aui_lane_sleep_and_eq_feedback #(
	parameter int NUM_LANES = aui_pkg::AUI_NUM_LANES,
	parameter bit EQ_FB_SUPPORTED = 1'b1
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// register bus
	input wire logic [aui_pkg::AUI_ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// link modes and sleep
	input wire aui_pkg::aui_mode_t egress_tx_mode,
	input wire aui_pkg::aui_mode_t ingress_tx_mode,
	input wire logic egress_sleep_request,
	// transmit lane data
	input wire logic [NUM_LANES-1:0][aui_pkg::AUI_WORD_W-1:0] egress_data_in,
	input wire logic [NUM_LANES-1:0][aui_pkg::AUI_WORD_W-1:0] ingress_data_in,
	output logic [NUM_LANES-1:0][aui_pkg::AUI_WORD_W-1:0] egress_data_out,
	output logic [NUM_LANES-1:0][aui_pkg::AUI_WORD_W-1:0] ingress_data_out,
	output logic [NUM_LANES-1:0] egress_tx_off,
	output logic [NUM_LANES-1:0] ingress_tx_off,
	// energy detect
	input wire aui_pkg::aui_mode_t egress_rx_mode,
	input wire aui_pkg::aui_mode_t ingress_rx_mode,
	input wire logic [aui_pkg::AUI_NUM_DIRS-1:0] energy_in,
	input wire logic [aui_pkg::AUI_NUM_DIRS-1:0] alert_valid,
	output logic [aui_pkg::AUI_NUM_DIRS-1:0] signal_ok,
	// equalization feedback, channel = dir * NUM_LANES + lane
	input wire aui_pkg::aui_step_t [aui_pkg::AUI_NUM_DIRS*NUM_LANES-1:0] remote_step_in,
	input wire logic [aui_pkg::AUI_NUM_DIRS*NUM_LANES-1:0] remote_step_valid,
	input wire aui_pkg::aui_step_t [aui_pkg::AUI_NUM_DIRS*NUM_LANES-1:0] partner_request,
	output aui_pkg::aui_step_t [aui_pkg::AUI_NUM_DIRS*NUM_LANES-1:0] fb_request,
	output aui_pkg::aui_step_t [aui_pkg::AUI_NUM_DIRS*NUM_LANES-1:0] local_step
);
	import aui_pkg::*;

	localparam int NUM_CH = AUI_NUM_DIRS * NUM_LANES;
	localparam int CH_W = $clog2(NUM_CH);
	// channel index counts egress lanes first, then ingress
	localparam logic [AUI_ADDR_W-3:0] NUM_CH_WORDS = (AUI_ADDR_W-2)'(NUM_CH);

	// ****************************************
	// bus slave state
	// ****************************************
	aui_bus_state_t bus_d;
	aui_bus_state_t bus_q;
	logic wait_d;
	logic wait_q;
	logic [31:0] rdata_d;
	logic [31:0] rdata_q;
	logic wr_fire;
	logic eq_hit;
	logic [CH_W-1:0] eq_idx;
	logic [AUI_ADDR_W-1:0] eq_off;

	// ****************************************
	// register state
	// ****************************************
	logic [1:0] ctrl_d;
	logic [1:0] ctrl_q;
	aui_step_t [NUM_CH-1:0] req_d;
	aui_step_t [NUM_CH-1:0] req_q;
	aui_step_t [NUM_CH-1:0] rem_d;
	aui_step_t [NUM_CH-1:0] rem_q;
	aui_step_t [NUM_CH-1:0] loc_d;
	aui_step_t [NUM_CH-1:0] loc_q;
	aui_step_t [NUM_CH-1:0] fb_d;
	aui_step_t [NUM_CH-1:0] fb_q;
	logic fb_enable;

	// ****************************************
	// helpers
	// ****************************************
	function automatic aui_step_t clamp_step(input aui_step_t s);
		aui_step_t r;
		r = s;
		if (s.pre > AUI_PRE_MAX) begin
			r.pre = AUI_PRE_MAX;
		end
		if (s.post > AUI_POST_MAX) begin
			r.post = AUI_POST_MAX;
		end
		return r;
	endfunction

	// ****************************************
	// address decode
	// ****************************************
	always_comb begin
		// an address below the base wraps high and fails the range compare
		eq_off = avs_address - AUI_REG_EQ_BASE;
		eq_idx = eq_off[CH_W+1:2];
		eq_hit = (avs_address >= AUI_REG_EQ_BASE) && (eq_off[1:0] == 2'h0)
			&& (eq_off[AUI_ADDR_W-1:2] < NUM_CH_WORDS);
	end

	// ****************************************
	// bus handshake
	// ****************************************
	// one wait cycle: data is read a cycle early so it stands at the release edge
	always_comb begin
		bus_d = bus_q;
		rdata_d = rdata_q;
		wr_fire = 1'b0;
		wait_d = 1'b1;
		case (bus_q)
			AUI_BUS_IDLE: begin
				if (avs_read || avs_write) begin
					bus_d = AUI_BUS_ACK;
					wait_d = 1'b0;
					// unmapped reads return zero
					rdata_d = 32'h0000_0000;
					if (avs_read) begin
						if (avs_address == AUI_REG_CTRL) begin
							rdata_d[1:0] = ctrl_q;
						end else if (avs_address == AUI_REG_STATUS) begin
							// lane 0 stands for every lane, all switch together
							rdata_d[3:0] = {signal_ok, ingress_tx_off[0], egress_tx_off[0]};
						end else if (eq_hit) begin
							rdata_d[AUI_EQ_REQ_LSB +: 6] = fb_q[eq_idx];
							rdata_d[AUI_EQ_REM_LSB +: 6] = rem_q[eq_idx];
							rdata_d[AUI_EQ_LOC_LSB +: 6] = loc_q[eq_idx];
						end
					end
				end
			end
			AUI_BUS_ACK: begin
				bus_d = AUI_BUS_IDLE;
				wr_fire = avs_write;
			end
			default: begin
				bus_d = AUI_BUS_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			bus_q <= AUI_BUS_IDLE;
			wait_q <= 1'b1;
			rdata_q <= 32'h0000_0000;
		end else begin
			bus_q <= bus_d;
			wait_q <= wait_d;
			rdata_q <= rdata_d;
		end
	end

	// a flop, not a decode of the state, so the master sees a clean level
	assign avs_waitrequest = wait_q;
	assign avs_readdata = rdata_q;

	// ****************************************
	// control register
	// ****************************************
	always_comb begin
		ctrl_d = ctrl_q;
		if (wr_fire && avs_address == AUI_REG_CTRL && avs_byteenable[0]) begin
			ctrl_d = avs_writedata[1:0];
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			ctrl_q <= AUI_CTRL_RESET;
		end else begin
			ctrl_q <= ctrl_d;
		end
	end

	assign fb_enable = EQ_FB_SUPPORTED && ctrl_q[AUI_CTRL_EQFB_BIT];

	// ****************************************
	// equalization feedback per channel
	// ****************************************
	genvar c;
	generate
		for (c = 0; c < NUM_CH; c++) begin : g_ch
			localparam logic [CH_W-1:0] CH_IDX = CH_W'(c);
			always_comb begin
				req_d[c] = req_q[c];
				rem_d[c] = rem_q[c];
				loc_d[c] = loc_q[c];
				// software write stands until rewritten, a request is not self-clearing
				if (wr_fire && eq_hit && eq_idx == CH_IDX && avs_byteenable[0]) begin
					req_d[c] = clamp_step(avs_writedata[AUI_EQ_REQ_LSB +: 6]);
				end
				if (remote_step_valid[c]) begin
					rem_d[c] = remote_step_in[c];
					rem_d[c].flag = 1'b0;
				end
				// partner asks this end to change its own transmitter
				if (partner_request[c].flag) begin
					loc_d[c] = clamp_step(partner_request[c]);
					loc_d[c].flag = 1'b0;
				end
				fb_d[c] = req_q[c];
				// flag is forced low whenever feedback is off
				fb_d[c].flag = fb_enable && req_q[c].flag;
			end

			always_ff @(posedge mclk) begin
				if (rst) begin
					req_q[c] <= AUI_STEP_RESET;
					rem_q[c] <= AUI_STEP_RESET;
					loc_q[c] <= AUI_STEP_RESET;
					fb_q[c] <= AUI_STEP_RESET;
				end else begin
					req_q[c] <= req_d[c];
					rem_q[c] <= rem_d[c];
					loc_q[c] <= loc_d[c];
					fb_q[c] <= fb_d[c];
				end
			end
		end
	endgenerate

	assign fb_request = fb_q;
	assign local_step = loc_q;

	// ****************************************
	// transmit shutdown per direction
	// ****************************************
	aui_tx_sleep #(
		.NUM_LANES(NUM_LANES)
	) u_egress_sleep (
		.mclk(mclk),
		.rst(rst),
		.disable_en(ctrl_q[AUI_CTRL_TXDIS_BIT]),
		.sleep_gate(egress_sleep_request),
		.tx_mode(egress_tx_mode),
		.lane_data_in(egress_data_in),
		.lane_data_out(egress_data_out),
		.lane_tx_off(egress_tx_off)
	);

	// ingress needs no sleep request, only the disable bit and the quiet mode
	aui_tx_sleep #(
		.NUM_LANES(NUM_LANES)
	) u_ingress_sleep (
		.mclk(mclk),
		.rst(rst),
		.disable_en(ctrl_q[AUI_CTRL_TXDIS_BIT]),
		.sleep_gate(1'b1),
		.tx_mode(ingress_tx_mode),
		.lane_data_in(ingress_data_in),
		.lane_data_out(ingress_data_out),
		.lane_tx_off(ingress_tx_off)
	);

	// ****************************************
	// energy detect per direction
	// ****************************************
	aui_energy_detect u_egress_ed (
		.mclk(mclk),
		.rst(rst),
		.rx_mode(egress_rx_mode),
		.energy_in(energy_in[AUI_DIR_EGRESS]),
		.alert_valid(alert_valid[AUI_DIR_EGRESS]),
		.signal_ok(signal_ok[AUI_DIR_EGRESS])
	);

	aui_energy_detect u_ingress_ed (
		.mclk(mclk),
		.rst(rst),
		.rx_mode(ingress_rx_mode),
		.energy_in(energy_in[AUI_DIR_INGRESS]),
		.alert_valid(alert_valid[AUI_DIR_INGRESS]),
		.signal_ok(signal_ok[AUI_DIR_INGRESS])
	);

endmodule

// ---- dv/aui_remote_model.sv ----
// far-end transceiver model: applies step requests and reports its setting
`timescale 1ns/1ns
module aui_remote_model (
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// from the block, plus the bench's ask
	input wire aui_pkg::aui_step_t [15:0] fb_request,
	input wire aui_pkg::aui_step_t ask,
	// toward the block
	output aui_pkg::aui_step_t [15:0] remote_step_in,
	output logic [15:0] remote_step_valid,
	output aui_pkg::aui_step_t [15:0] partner_request
);
	import aui_pkg::*;
	aui_step_t [15:0] set_q, set_d;
	logic [15:0] val_q, val_d;
	always_comb begin
		set_d = set_q;
		val_d = '0;
		for (int i = 0; i < 16; i++) begin
			if (fb_request[i].flag && fb_request[i][4:0] != set_q[i][4:0]) begin
				set_d[i] = {1'b0, fb_request[i].pre, (fb_request[i].post > 3'h5) ? 3'h5 : fb_request[i].post};
				val_d[i] = 1'b1;
			end
			// off the strobe the lines carry junk, never a stale copy
			remote_step_in[i] = val_q[i] ? set_q[i] : ~set_q[i];
		end
	end
	always_ff @(posedge mclk) begin
		set_q <= rst ? '0 : set_d;
		val_q <= rst ? '0 : val_d;
	end
	assign remote_step_valid = val_q;
	assign partner_request = {16{ask}};
endmodule

// ---- dv/aui_properties.sv ----
// port-level assertions for the lane sleep and feedback top
`timescale 1ns/1ns
module aui_properties #(
	parameter int NUM_LANES = aui_pkg::AUI_NUM_LANES
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// bus and sleep
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic avs_waitrequest,
	input wire aui_pkg::aui_mode_t egress_tx_mode,
	input wire aui_pkg::aui_mode_t ingress_tx_mode,
	input wire logic egress_sleep_request,
	input wire logic [NUM_LANES-1:0][aui_pkg::AUI_WORD_W-1:0] egress_data_out,
	input wire logic [NUM_LANES-1:0] egress_tx_off,
	input wire logic [NUM_LANES-1:0] ingress_tx_off,
	// energy detect and feedback
	input wire aui_pkg::aui_mode_t ingress_rx_mode,
	input wire logic [aui_pkg::AUI_NUM_DIRS-1:0] energy_in,
	input wire logic [aui_pkg::AUI_NUM_DIRS-1:0] alert_valid,
	input wire logic [aui_pkg::AUI_NUM_DIRS-1:0] signal_ok,
	input wire aui_pkg::aui_step_t [aui_pkg::AUI_NUM_DIRS*NUM_LANES-1:0] fb_request,
	input wire aui_pkg::aui_step_t [aui_pkg::AUI_NUM_DIRS*NUM_LANES-1:0] local_step
);
	import aui_pkg::*;
	logic steps_ok;
	always_comb begin
		steps_ok = 1'b1;
		for (int i = 0; i < AUI_NUM_DIRS*NUM_LANES; i++) begin
			if (fb_request[i].pre > AUI_PRE_MAX || fb_request[i].post > AUI_POST_MAX) steps_ok = 1'b0;
			if (local_step[i].post > AUI_POST_MAX || local_step[i].flag) steps_ok = 1'b0;
		end
	end
	default clocking dcb @(posedge mclk); endclocking
	default disable iff (rst);
	egress_gate_a: assert property (
		|egress_tx_off |-> $past(egress_tx_mode) == AUI_MODE_QUIET && $past(egress_sleep_request))
		else $error("egress lanes off outside quiet sleep");
	ingress_gate_a: assert property (
		|ingress_tx_off |-> $past(ingress_tx_mode) == AUI_MODE_QUIET) else $error("ingress lanes off outside quiet");
	all_lanes_a: assert property (
		(egress_tx_off == '0 || &egress_tx_off) && (ingress_tx_off == '0 || &ingress_tx_off))
		else $error("lanes not switched together");
	lanes_back_a: assert property (
		(egress_tx_mode != AUI_MODE_QUIET |=> egress_tx_off == '0) and
		(ingress_tx_mode != AUI_MODE_QUIET |=> ingress_tx_off == '0)) else $error("lanes stay off");
	alert_word_a: assert property (
		egress_tx_mode == AUI_MODE_ALERT |=> egress_data_out == {NUM_LANES{AUI_ALERT_WORD}})
		else $error("alert pattern missing");
	ok_fast_a: assert property (
		ingress_rx_mode == AUI_MODE_QUIET && alert_valid[1] |=> signal_ok[1]) else $error("alert not detected");
	ok_cause_a: assert property (
		$rose(signal_ok[1]) && $past(ingress_rx_mode) == AUI_MODE_QUIET |-> $past(alert_valid[1]))
		else $error("ok in quiet without alert");
	fail_quiet_a: assert property (
		$past(ingress_rx_mode) == AUI_MODE_DATA && ingress_rx_mode == AUI_MODE_QUIET && !energy_in[1]
		&& !alert_valid[1] |=> !signal_ok[1]) else $error("no fail after data to quiet");
	step_range_a: assert property (steps_ok) else $error("step code out of range");
	bus_answer_a: assert property (
		(avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
		else $error("bus answer not one cycle");
	cover property (|egress_tx_off);
	cover property ($rose(signal_ok[1]) && ingress_rx_mode == AUI_MODE_QUIET);
	cover property (fb_request[0].flag);
endmodule
bind aui_lane_sleep_and_eq_feedback aui_properties #(.NUM_LANES(NUM_LANES)) u_props (.mclk, .rst,
	.avs_read, .avs_write, .avs_waitrequest, .egress_tx_mode, .ingress_tx_mode, .egress_sleep_request,
	.egress_data_out, .egress_tx_off, .ingress_tx_off, .ingress_rx_mode, .energy_in, .alert_valid,
	.signal_ok, .fb_request, .local_step);

// ---- dv/aui_lane_sleep_and_eq_feedback_test.sv ----
// directed bench for the lane sleep, energy detect and feedback top
`timescale 1ns/1ns
module aui_lane_sleep_and_eq_feedback_test;
	import aui_pkg::*;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] avs_address = 8'h00;
	logic avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest, egress_sleep_request = 1'b0;
	logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
	logic [3:0] avs_byteenable = 4'hF;
	// this block answers as the component nearer the medium
	localparam int near_pcs_dev = 11, near_medium_dev = 10;
	aui_mode_t egress_tx_mode = AUI_MODE_DATA, ingress_tx_mode = AUI_MODE_DATA;
	aui_mode_t egress_rx_mode = AUI_MODE_DATA, ingress_rx_mode = AUI_MODE_DATA;
	logic [7:0][15:0] egress_data_in = '0, ingress_data_in = '0, egress_data_out, ingress_data_out;
	logic [7:0] egress_tx_off, ingress_tx_off;
	logic [1:0] energy_in = 2'h0, alert_valid = 2'h0, signal_ok;
	aui_step_t [15:0] remote_step_in, partner_request, fb_request, local_step;
	logic [15:0] remote_step_valid;
	aui_step_t ask = AUI_STEP_RESET;
	logic [5:0] s;
	int wch;
	int n_errors = 0, comparisons = 0;
	always #5 mclk = ~mclk;
	aui_lane_sleep_and_eq_feedback u_dut (.mclk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
		.avs_byteenable, .avs_readdata, .avs_waitrequest, .egress_tx_mode, .ingress_tx_mode,
		.egress_sleep_request, .egress_data_in, .ingress_data_in, .egress_data_out, .ingress_data_out,
		.egress_tx_off, .ingress_tx_off, .egress_rx_mode, .ingress_rx_mode, .energy_in, .alert_valid,
		.signal_ok, .remote_step_in, .remote_step_valid, .partner_request, .fb_request, .local_step);
	aui_remote_model u_far (.mclk, .rst, .fb_request, .ask, .remote_step_in, .remote_step_valid,
		.partner_request);
	// ****
	// tasks
	// ****
	task automatic finish_test();
		if (n_errors == 0 && comparisons > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic chk(input logic [127:0] got, input logic [127:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
	endtask
	// one request held until waitrequest is seen low
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge mclk);
		avs_address <= a;
		avs_writedata <= d;
		avs_read <= !wr;
		avs_write <= wr;
		for (k = 0; k < 20; k++) begin
			@(posedge mclk);
			if (avs_waitrequest === 1'b0) break;
		end
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		if (k == 20) begin
			n_errors++;
			finish_test();
		end
	endtask
	// polling covers values that arrive from the far end a few cycles late
	task automatic expect_reg(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input int tries);
		for (int t = 0; t < tries; t++) begin
			bus(1'b0, a, 32'h0);
			if ((rd & m) === e) break;
		end
		chk(rd & m, e);
	endtask
	// ****
	// scenarios
	// ****
	initial begin
		tick(16);
		rst <= 1'b0;
		expect_reg(AUI_REG_CTRL, 32'hFFFFFFFF, 32'h0, 1);
		bus(1'b1, 8'h20, 32'hFFFFFFFF);
		expect_reg(8'h20, 32'hFFFFFFFF, 32'h0, 1);
		bus(1'b1, AUI_REG_CTRL, 32'h3);
		egress_tx_mode <= AUI_MODE_QUIET;
		ingress_tx_mode <= AUI_MODE_QUIET;
		tick(2);
		chk(egress_tx_off, 8'h00);
		chk(ingress_tx_off, 8'hFF);
		egress_sleep_request <= 1'b1;
		tick(2);
		chk(egress_tx_off, 8'hFF);
		expect_reg(AUI_REG_STATUS, 32'h3, 32'h3, 1);
		egress_tx_mode <= AUI_MODE_ALERT;
		ingress_tx_mode <= AUI_MODE_ALERT;
		egress_data_in <= {8{16'h1234}};
		ingress_data_in <= {8{16'h5A5A}};
		tick(2);
		chk({egress_tx_off, ingress_tx_off}, 16'h0);
		chk({egress_data_out, ingress_data_out}, {16{AUI_ALERT_WORD}});
		egress_tx_mode <= AUI_MODE_DATA;
		ingress_tx_mode <= AUI_MODE_DATA;
		tick(2);
		chk({egress_data_out, ingress_data_out}, {{8{16'h1234}}, {8{16'h5A5A}}});
		energy_in <= 2'h3;
		tick(2);
		energy_in <= 2'h2;
		tick(2);
		chk(signal_ok, 2'h2);
		energy_in <= 2'h0;
		egress_rx_mode <= AUI_MODE_QUIET;
		ingress_rx_mode <= AUI_MODE_QUIET;
		tick(2);
		chk(signal_ok, 2'h0);
		energy_in <= 2'h3;
		tick(4);
		chk(signal_ok, 2'h0);
		alert_valid <= 2'h3;
		tick(2);
		chk(signal_ok, 2'h3);
		alert_valid <= 2'h0;
		// lane 0 on both sides first, then lanes 1 to 7
		for (int ln = 0; ln < 8; ln++) begin
			for (int dr = 0; dr < 2; dr++) begin
				wch = dr * 8 + ln;
				bus(1'b1, AUI_REG_EQ_BASE + 8'(4*wch), {26'h0, 1'b1, 2'(wch), 3'(wch >> 2)});
			end
		end
		tick(2);
		for (int ch = 0; ch < 16; ch++) begin
			s = {1'b1, 2'(ch), 3'(ch >> 2)};
			chk(fb_request[ch], s);
			expect_reg(AUI_REG_EQ_BASE + 8'(4*ch), 32'h3F3F, {18'h0, 1'b0, s[4:0], 2'h0, s}, 8);
		end
		ask <= {1'b1, 2'h2, 3'h7};
		tick(1);
		ask <= AUI_STEP_RESET;
		tick(2);
		chk(local_step, {16{6'h15}});
		expect_reg(AUI_REG_EQ_BASE, 32'h3F0000, 32'h150000, 1);
		bus(1'b1, AUI_REG_EQ_BASE, 32'h3F);
		expect_reg(AUI_REG_EQ_BASE, 32'h3F, 32'h3D, 1);
		bus(1'b1, AUI_REG_EQ_BASE, 32'h1D);
		tick(2);
		chk(fb_request[0], 6'h1D);
		bus(1'b1, AUI_REG_CTRL, 32'h1);
		tick(2);
		chk(fb_request[1].flag, 1'b0);
		expect_reg(AUI_REG_EQ_BASE + 8'h04, 32'h20, 32'h0, 1);
		avs_byteenable <= 4'hE;
		bus(1'b1, AUI_REG_CTRL, 32'h2);
		avs_byteenable <= 4'hF;
		expect_reg(AUI_REG_CTRL, 32'h3, 32'h1, 1);
		finish_test();
	end
endmodule
